// ### daalm_line_model.sv
// Line-side partner: framing, receive samples and loop status
`timescale 1ns/1ps
module daalm_line_model
  import daalm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        link_enable,
  input  wire logic [7:0]  link_tx_ctrl,
  input  wire logic [3:0]  gap,
  input  wire logic [4:0]  loop_code,
  input  wire logic        ring_on,
  input  wire logic        dropout_on,
  input  wire logic        cid_on,
  output logic             link_frame_lock,
  output logic             link_rx_valid,
  output logic [15:0]      link_rx_sample,
  output logic [7:0]       link_rx_status
);
  logic [3:0]  cnt_reg;
  logic [15:0] smp_reg;
  logic        frame;

  assign frame = resetn && link_frame_lock && link_enable && cnt_reg == gap;

  // Framing only while the link is enabled, one frame per gap+1 cycles
  always_ff @(posedge clk) begin
    if (!resetn || !link_enable) begin
      link_frame_lock <= 1'b0;
      cnt_reg         <= 4'h0;
    end else begin
      link_frame_lock <= 1'b1;
      cnt_reg         <= (cnt_reg >= gap) ? 4'h0 : cnt_reg + 4'h1;
    end
  end

  // Frame payload; idle lines toggle so stale data never looks valid
  always_ff @(posedge clk) begin
    link_rx_valid <= frame;
    if (!resetn) begin
      smp_reg        <= 16'h0000;
      link_rx_sample <= 16'h0000;
      link_rx_status <= 8'h00;
    end else if (frame) begin
      smp_reg        <= smp_reg + 16'h0101;
      link_rx_sample <= smp_reg;
      link_rx_status <= {cid_on, dropout_on, ring_on, link_tx_ctrl[0] ? loop_code : 5'h00};
    end else begin
      link_rx_sample <= ~link_rx_sample;
      link_rx_status <= ~link_rx_status;
    end
  end
endmodule // daalm_line_model

// ### daalm_pkg.sv
// Register map, field layout, reset values and timing for the link and loop monitor
package daalm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_IRQ_MASK    = 6'h03;
  localparam logic [5:0] IDX_IRQ_FLAGS   = 6'h04;
  localparam logic [5:0] IDX_HOOK_CTRL   = 6'h05;
  localparam logic [5:0] IDX_POWER_CTRL  = 6'h06;
  localparam logic [5:0] IDX_RATE_CTRL   = 6'h07;
  localparam logic [5:0] IDX_LINK_STATUS = 6'h0C;
  localparam logic [5:0] IDX_MON_RX_LVL  = 6'h14;
  localparam logic [5:0] IDX_MON_TX_LVL  = 6'h15;
  localparam int         APB_AW          = 8;

  // Interrupt flag positions (flags and mask share the layout)
  localparam int IRQ_RING_POS     = 0;
  localparam int IRQ_DROPOUT_POS  = 3;
  localparam int IRQ_OVERLOAD_POS = 5;
  localparam int IRQ_READY_POS    = 6;

  // Hook control fields
  localparam int HOOK_OFFHOOK_POS = 0;
  localparam int HOOK_ACTIVE_POS  = 1;
  localparam int HOOK_RING_POS    = 2;
  localparam int HOOK_CID_EN_POS  = 3;
  localparam int HOOK_CID_POS     = 4;

  // Power and status fields
  localparam int PWR_LINE_PDN_POS = 4;
  localparam int STAT_READY_POS   = 6;
  localparam int LOOP_W           = 5;
  localparam int RATE_W           = 4;

  // Reset values
  localparam logic [7:0] POWER_RESET = 8'h10;
  localparam logic [7:0] RATE_RESET  = 8'h00;
  localparam logic [7:0] MON_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'h00;

  // Loop current codes: 3.3 mA per step
  localparam logic [4:0] LOOP_MAX_CODE = 5'h1F;
  localparam logic [4:0] LOOP_LOW_TOP  = 5'h03;

  // Link word layout from the line side
  localparam int RXS_RING_POS    = 5;
  localparam int RXS_DROPOUT_POS = 6;
  localparam int RXS_CID_POS     = 7;

  // Timing
  localparam int CLK_MHZ            = 40;
  localparam int OFFHOOK_LATENCY_US = 250;
  localparam int OFFHOOK_CYCLES     = OFFHOOK_LATENCY_US * CLK_MHZ;
  localparam int FRAME_LOCK_CYCLES  = 64;

endpackage

// ### daalm_properties.sv
// Port checker for the link and loop monitor
`timescale 1ns/1ps
module daalm_properties
  import daalm_pkg::*;
#(
  parameter int OFFHOOK_DELAY = OFFHOOK_CYCLES,
  parameter int LOCK_DELAY    = FRAME_LOCK_CYCLES
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        link_enable,
  input wire logic        link_rx_valid,
  input wire logic [15:0] link_rx_sample,
  input wire logic        link_tx_valid,
  input wire logic [7:0]  link_tx_ctrl,
  input wire logic [15:0] rx_sample,
  input wire logic        rx_sample_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Link off and quiet out of reset
  property p_reset_off; $rose(resetn) |-> !link_enable && link_tx_ctrl == 8'h00; endproperty
  a_reset_off: assert property (p_reset_off) else $error("link on after reset");
  // Link enable moves only after a completed write
  property p_pwr_write;
    $changed(link_enable) && $past(resetn) |->
      $past(psel && penable && pready && pwrite, 2) ||
      $past(psel && penable && pready && pwrite, 3);
  endproperty
  a_pwr_write: assert property (p_pwr_write) else $error("link enable moved alone");
  // No frame sent while the link is off
  property p_tx_link; link_tx_valid |-> link_enable; endproperty
  a_tx_link: assert property (p_tx_link) else $error("frame sent with link off");
  // Control word silent while the link stays off
  property p_ctrl_quiet; !link_enable && !$past(link_enable) |-> link_tx_ctrl == 8'h00; endproperty
  a_ctrl_quiet: assert property (p_ctrl_quiet) else $error("control sent with link off");
  // Receive sample is the frame of the cycle before, paired with transmit
  property p_rx_copy;
    rx_sample_valid |-> $past(link_rx_valid) && rx_sample == $past(link_rx_sample) && link_tx_valid;
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("receive sample not passed");
  // One wait state on every access
  property p_one_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("access answer misplaced");
  // Error only with the answer and empty data
  property p_err_ready; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside answer");
  // Upper bits read zero, data only with the answer
  property p_narrow; (pready ? prdata[31:8] : prdata) == '0; endproperty
  a_narrow: assert property (p_narrow) else $error("read data wider than a register");
endmodule // daalm_properties

bind daalm_top daalm_properties #(.OFFHOOK_DELAY(OFFHOOK_DELAY), .LOCK_DELAY(LOCK_DELAY))
  i_daalm_properties (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .link_enable(link_enable), .link_rx_valid(link_rx_valid), .link_rx_sample(link_rx_sample),
  .link_tx_valid(link_tx_valid), .link_tx_ctrl(link_tx_ctrl), .rx_sample(rx_sample),
  .rx_sample_valid(rx_sample_valid));

// ### daalm_sticky.sv
// Sticky event flags with set priority over clear
`timescale 1ns/1ps
module daalm_sticky #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] set_vec,
  input  wire logic [W-1:0] clr_vec,
  output logic      [W-1:0] flag_reg
);

  // Set wins when set and clear meet in one cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= (flag_reg & ~clr_vec) | set_vec;
    end
  end

endmodule // daalm_sticky

// ### daalm_top.sv
// System-side link bring-up, barrier traffic and loop current monitor
//
// Operation
// [RQ1] Software first picks the converter sample rate in the low four bits of register 7.
// [RQ2] Software then powers the line side up by clearing bit 4 of register 6.
// [RQ3] Software sets the receive and transmit monitor levels in registers 20 and 21.
// [RQ4] Software moves no sample data before it has seen the ready flag in register 12.
// [RQ5] After reset the barrier link is off and the line power-down bit reads one.
// [RQ6] No traffic crosses the barrier until power-down is clear and the ready flag is high.
// [RQ7] Transmit, receive, control, ring and caller ID data all share the one barrier link.
// [RQ8] After bring-up, off-hook commands are taken and on-hook ring monitoring works.
// [RQ9] While off-hook the five-bit loop current code sits in the low bits of register 12.
// [RQ10] Software may read a marked drop in loop current as a parallel handset going off-hook.
// [RQ11] On an all-zero loop code software checks the dropout flag, bit 3 of register 4.
// [RQ12] Each loop code step stands for 3.3 mA; below the operating minimum it is undefined.
// [RQ13] Code 11111 means excess current, 00000 to 00011 too little, the rest normal.
// [RQ14] The overload flag is raised when the loop code reaches its top value.
// [RQ15] Every register is eight bits wide and unassigned bits read as zero; the interrupt mask in register 3 reads back all eight bits as written.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module daalm_top
  import daalm_pkg::*;
#(
  parameter int OFFHOOK_DELAY = OFFHOOK_CYCLES,
  parameter int LOCK_DELAY    = FRAME_LOCK_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  // Barrier link
  input  wire logic              link_frame_lock,
  input  wire logic              link_rx_valid,
  input  wire logic [15:0]       link_rx_sample,
  input  wire logic [7:0]        link_rx_status,
  output logic                   link_enable,
  output logic                   link_tx_valid,
  output logic      [15:0]       link_tx_sample,
  output logic      [7:0]        link_tx_ctrl,
  // User sample side
  input  wire logic [15:0]       tx_sample,
  input  wire logic              tx_sample_valid,
  output logic                   tx_sample_ready,
  output logic      [15:0]       rx_sample,
  output logic                   rx_sample_valid,
  output logic      [7:0]        monitor_rx_level,
  output logic      [7:0]        monitor_tx_level,
  output logic      [3:0]        sample_rate_select
);

  localparam int OH_CW = $clog2(OFFHOOK_DELAY + 1);
  localparam int LK_CW = $clog2(LOCK_DELAY + 1);

  // Register state
  logic [7:0]       power_control_reg;
  logic [7:0]       rate_control_reg;
  logic [7:0]       mon_rx_reg;
  logic [7:0]       mon_tx_reg;
  logic [7:0]       irq_mask_reg;
  logic             offhook_cmd_reg;
  logic             cid_enable_reg;
  logic [7:0]       irq_flags;
  logic [7:0]       irq_set;
  logic [7:0]       irq_clr;

  // Link state
  logic             ready_reg;
  logic [LK_CW-1:0] lock_cnt_reg;
  logic [OH_CW-1:0] oh_cnt_reg;
  logic             offhook_active_reg;
  logic [4:0]       loop_level_reg;
  logic             ring_reg;
  logic             cid_reg;
  logic             dropout_prev_reg;
  logic             ring_prev_reg;
  logic             ready_prev_reg;
  logic             tx_pending_reg;
  logic [15:0]      tx_hold_reg;

  // Bus decode
  logic             access;
  logic             done;
  logic [5:0]       word_idx;
  logic             mapped;
  logic [7:0]       rd_byte;
  logic             line_pdn;
  logic             traffic_ok;

  assign access     = psel && penable;
  assign done       = access && pready;
  assign word_idx   = paddr[7:2];
  assign line_pdn   = power_control_reg[PWR_LINE_PDN_POS];
  assign traffic_ok = !line_pdn && ready_reg; // [RQ6]

  // Address map check
  always_comb begin
    unique case (word_idx)
      IDX_IRQ_MASK, IDX_IRQ_FLAGS, IDX_HOOK_CTRL, IDX_POWER_CTRL,
      IDX_RATE_CTRL, IDX_LINK_STATUS, IDX_MON_RX_LVL, IDX_MON_TX_LVL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read mux, unassigned bits zero except in the interrupt mask, which reads back all eight bits
  always_comb begin
    rd_byte = 8'h00; // [RQ15]
    unique case (word_idx)
      IDX_IRQ_MASK:    rd_byte = irq_mask_reg;
      IDX_IRQ_FLAGS:   rd_byte = irq_flags; // [RQ11]
      IDX_HOOK_CTRL: begin
        rd_byte[HOOK_OFFHOOK_POS] = offhook_cmd_reg;
        rd_byte[HOOK_ACTIVE_POS]  = offhook_active_reg;
        rd_byte[HOOK_RING_POS]    = ring_reg;
        rd_byte[HOOK_CID_EN_POS]  = cid_enable_reg;
        rd_byte[HOOK_CID_POS]     = cid_reg;
      end
      IDX_POWER_CTRL:  rd_byte = power_control_reg & POWER_RESET;
      IDX_RATE_CTRL:   rd_byte = {4'h0, rate_control_reg[RATE_W-1:0]};
      IDX_LINK_STATUS: begin
        rd_byte[LOOP_W-1:0]     = loop_level_reg; // [RQ9]
        rd_byte[STAT_READY_POS] = ready_reg; // [RQ4]
      end
      IDX_MON_RX_LVL:  rd_byte = mon_rx_reg;
      IDX_MON_TX_LVL:  rd_byte = mon_tx_reg;
      default:         rd_byte = 8'h00;
    endcase
  end

  // APB answer: one wait state, data and error registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready  <= 1'b1;
      prdata  <= (!pwrite && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= !mapped;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Power and rate registers; link starts powered down
  always_ff @(posedge clk) begin
    if (!resetn) begin
      power_control_reg <= POWER_RESET; // [RQ5]
      rate_control_reg  <= RATE_RESET;
    end else if (done && pwrite) begin
      if (word_idx == IDX_POWER_CTRL) begin
        power_control_reg <= pwdata[7:0] & POWER_RESET; // [RQ2]
      end
      if (word_idx == IDX_RATE_CTRL) begin
        rate_control_reg <= {4'h0, pwdata[RATE_W-1:0]}; // [RQ1]
      end
    end
  end

  // Monitor levels and interrupt mask
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mon_rx_reg   <= MON_RESET;
      mon_tx_reg   <= MON_RESET;
      irq_mask_reg <= MASK_RESET;
    end else if (done && pwrite) begin
      if (word_idx == IDX_MON_RX_LVL) begin
        mon_rx_reg <= pwdata[7:0]; // [RQ3]
      end
      if (word_idx == IDX_MON_TX_LVL) begin
        mon_tx_reg <= pwdata[7:0]; // [RQ3]
      end
      if (word_idx == IDX_IRQ_MASK) begin
        irq_mask_reg <= pwdata[7:0];
      end
    end
  end

  // Hook control; off-hook only taken once the link is up
  always_ff @(posedge clk) begin
    if (!resetn) begin
      offhook_cmd_reg <= 1'b0;
      cid_enable_reg  <= 1'b0;
    end else if (!traffic_ok) begin
      offhook_cmd_reg <= 1'b0;
    end else if (done && pwrite && word_idx == IDX_HOOK_CTRL) begin
      offhook_cmd_reg <= pwdata[HOOK_OFFHOOK_POS]; // [RQ8]
      cid_enable_reg  <= pwdata[HOOK_CID_EN_POS];
    end
  end

  // Frame lock must hold for a while before the ready flag rises
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lock_cnt_reg <= '0;
      ready_reg    <= 1'b0;
    end else if (line_pdn || !link_frame_lock) begin
      lock_cnt_reg <= '0;
      ready_reg    <= 1'b0; // [RQ6]
    end else if (lock_cnt_reg == LK_CW'(LOCK_DELAY)) begin
      ready_reg    <= 1'b1;
    end else begin
      lock_cnt_reg <= lock_cnt_reg + 1'b1;
    end
  end

  // Off-hook takes effect on the line after the barrier latency
  always_ff @(posedge clk) begin
    if (!resetn) begin
      oh_cnt_reg         <= '0;
      offhook_active_reg <= 1'b0;
    end else if (!offhook_cmd_reg) begin
      oh_cnt_reg         <= '0;
      offhook_active_reg <= 1'b0;
    end else if (oh_cnt_reg == OH_CW'(OFFHOOK_DELAY)) begin
      offhook_active_reg <= 1'b1; // [RQ8]
    end else begin
      oh_cnt_reg <= oh_cnt_reg + 1'b1;
    end
  end

  // Line status from the barrier: loop code only while off-hook
  always_ff @(posedge clk) begin
    if (!resetn) begin
      loop_level_reg <= 5'h00;
      ring_reg       <= 1'b0;
      cid_reg        <= 1'b0;
    end else if (!traffic_ok) begin
      loop_level_reg <= 5'h00;
      ring_reg       <= 1'b0;
      cid_reg        <= 1'b0;
    end else if (link_rx_valid) begin
      // Code passed through as measured, 3.3 mA per step
      loop_level_reg <= offhook_active_reg ? link_rx_status[LOOP_W-1:0] : 5'h00; // [RQ9] [RQ12]
      ring_reg       <= !offhook_active_reg && link_rx_status[RXS_RING_POS]; // [RQ8] [RQ7]
      cid_reg        <= cid_enable_reg && link_rx_status[RXS_CID_POS]; // [RQ7]
    end
  end

  // Edge history for event detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dropout_prev_reg <= 1'b0;
      ring_prev_reg    <= 1'b0;
      ready_prev_reg   <= 1'b0;
    end else begin
      // Dropout history follows the line status frame to frame, not the frame pulse
      if (!traffic_ok) begin
        dropout_prev_reg <= 1'b0;
      end else if (link_rx_valid) begin
        dropout_prev_reg <= offhook_active_reg && link_rx_status[RXS_DROPOUT_POS];
      end
      ring_prev_reg    <= ring_reg;
      ready_prev_reg   <= ready_reg;
    end
  end

  // Interrupt events and read-to-clear
  always_comb begin
    irq_set = 8'h00;
    irq_set[IRQ_RING_POS]     = ring_reg && !ring_prev_reg;
    irq_set[IRQ_DROPOUT_POS]  = traffic_ok && link_rx_valid && offhook_active_reg
                                && link_rx_status[RXS_DROPOUT_POS]
                                && !dropout_prev_reg; // [RQ11]
    irq_set[IRQ_OVERLOAD_POS] = offhook_active_reg
                                && loop_level_reg == LOOP_MAX_CODE; // [RQ14] [RQ13]
    irq_set[IRQ_READY_POS]    = ready_reg && !ready_prev_reg;
    irq_clr = (done && !pwrite && word_idx == IDX_IRQ_FLAGS) ? 8'hFF : 8'h00;
  end

  daalm_sticky #(
    .W (8)
  ) u_irq_flags (
    .clk      (clk),
    .resetn   (resetn),
    .set_vec  (irq_set),
    .clr_vec  (irq_clr),
    .flag_reg (irq_flags)
  );

  // Level interrupt from unmasked flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_flags & ~irq_clr) | irq_set) & irq_mask_reg); // Set beats clear
    end
  end

  // Transmit holding word; stalls until the next link frame
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_pending_reg <= 1'b0;
      tx_hold_reg    <= 16'h0000;
    end else if (!traffic_ok) begin
      tx_pending_reg <= 1'b0; // [RQ6]
    end else if (tx_sample_valid && tx_sample_ready) begin
      tx_pending_reg <= 1'b1;
      tx_hold_reg    <= tx_sample;
    end else if (link_rx_valid) begin
      tx_pending_reg <= 1'b0;
    end
  end

  // Ready to take a sample only when the holding word is free
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_sample_ready <= 1'b0;
    end else begin
      tx_sample_ready <= traffic_ok && !(tx_pending_reg && !link_rx_valid)
                         && !(tx_sample_valid && tx_sample_ready); // [RQ6]
    end
  end

  // One link word per line-side frame: sample plus control
  always_ff @(posedge clk) begin
    if (!resetn) begin
      link_tx_valid  <= 1'b0;
      link_tx_sample <= 16'h0000;
      link_tx_ctrl   <= 8'h00;
    end else begin
      link_tx_valid  <= traffic_ok && link_rx_valid; // [RQ6]
      link_tx_sample <= (traffic_ok && tx_pending_reg) ? tx_hold_reg : 16'h0000; // [RQ7]
      link_tx_ctrl   <= traffic_ok ? {2'b00, cid_enable_reg, rate_control_reg[RATE_W-1:0],
                                      offhook_cmd_reg} : 8'h00; // [RQ7]
    end
  end

  // Received samples to the user side
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_sample       <= 16'h0000;
      rx_sample_valid <= 1'b0;
    end else begin
      rx_sample_valid <= traffic_ok && link_rx_valid; // [RQ6] [RQ7]
      if (traffic_ok && link_rx_valid) begin
        rx_sample <= link_rx_sample;
      end
    end
  end

  // Configuration outputs toward the converter and monitor
  always_ff @(posedge clk) begin
    if (!resetn) begin
      link_enable        <= 1'b0;
      monitor_rx_level   <= MON_RESET;
      monitor_tx_level   <= MON_RESET;
      sample_rate_select <= 4'h0;
    end else begin
      link_enable        <= !line_pdn; // [RQ5] [RQ2]
      monitor_rx_level   <= mon_rx_reg;
      monitor_tx_level   <= mon_tx_reg;
      sample_rate_select <= rate_control_reg[RATE_W-1:0];
    end
  end

endmodule // daalm_top

// ### tb_top.sv
// Testbench: host bring-up, barrier traffic and loop monitor
`timescale 1ns/1ps
module tb_top
  import daalm_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic r;} daalm_row_t;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, er, link_frame_lock, link_rx_valid, link_enable, link_tx_valid;
  logic [15:0] link_rx_sample, link_tx_sample, rx_sample, tx_sample = 16'h0000;
  logic [7:0] link_rx_status, link_tx_ctrl, monitor_rx_level, monitor_tx_level;
  logic tx_sample_valid = 1'b0, tx_sample_ready, rx_sample_valid;
  logic [3:0] sample_rate_select, gap = 4'h2;
  logic [4:0] loop_code = 5'h00;
  logic ring_on = 1'b0, dropout_on = 1'b0, cid_on = 1'b0;
  int fails = 0, check_count = 0, n;
  // Plain register cases: write, address, data, expected read, expected error
  daalm_row_t rows [12] = '{'{0, 8'h18, 0, 8'h10, 0}, '{0, 8'h1C, 0, 0, 0}, '{0, 8'h50, 0, 0, 0},
    '{0, 8'h54, 0, 0, 0}, '{0, 8'h30, 0, 0, 0}, '{0, 8'h08, 0, 0, 1}, '{1, 8'hFC, 8'h55, 0, 1},
    '{1, 8'h1C, 8'hFF, 0, 0}, '{0, 8'h1C, 0, 8'h0F, 0}, '{1, 8'h14, 8'h09, 0, 0},
    '{0, 8'h14, 0, 0, 0}, '{1, 8'h0C, 8'h69, 0, 0}};
  logic [4:0] codes [3] = '{5'h05, 5'h1F, 5'h00};
  logic [7:0] fexp [3] = '{8'h00, 8'h20, 8'h28};

  always #12.5 clk = ~clk;

  daalm_top #(.OFFHOOK_DELAY(8), .LOCK_DELAY(4)) i_daalm_top (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link_frame_lock(link_frame_lock), .link_rx_valid(link_rx_valid),
    .link_rx_sample(link_rx_sample), .link_rx_status(link_rx_status),
    .link_enable(link_enable), .link_tx_valid(link_tx_valid), .link_tx_sample(link_tx_sample),
    .link_tx_ctrl(link_tx_ctrl), .tx_sample(tx_sample), .tx_sample_valid(tx_sample_valid),
    .tx_sample_ready(tx_sample_ready), .rx_sample(rx_sample), .rx_sample_valid(rx_sample_valid),
    .monitor_rx_level(monitor_rx_level), .monitor_tx_level(monitor_tx_level),
    .sample_rate_select(sample_rate_select));
  daalm_line_model i_daalm_line_model (.clk(clk), .resetn(resetn), .link_enable(link_enable),
    .link_tx_ctrl(link_tx_ctrl), .gap(gap), .loop_code(loop_code), .ring_on(ring_on),
    .dropout_on(dropout_on), .cid_on(cid_on), .link_frame_lock(link_frame_lock),
    .link_rx_valid(link_rx_valid), .link_rx_sample(link_rx_sample),
    .link_rx_status(link_rx_status));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; data and error taken at the answer edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (k >= 20) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  task automatic conclude();
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(25 * 20000);
    fails++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
      if (!rows[i].w) chk(rd, {24'h0, rows[i].e});
      chk(er, rows[i].r);
    end
    apb(1'b1, 8'h50, 32'h000000A5);
    apb(1'b1, 8'h54, 32'h0000005A);
    repeat (2) @(negedge clk);
    chk({monitor_rx_level, monitor_tx_level, sample_rate_select}, 20'hA55AF);
    apb(1'b1, 8'h18, 32'h0);
    n = 0;
    do begin
      apb(1'b0, 8'h30, 32'h0);
      n++;
    end while (rd[6] !== 1'b1 && n < 30);
    chk(rd, 32'h40);
    chk({link_enable, irq}, 2'b11);
    rdchk(8'h10, 8'h40);
    @(negedge clk);
    @(negedge clk);
    chk(irq, 1'b0);
    // User sample crosses on the next frame
    @(posedge clk);
    tx_sample <= 16'h1234;
    tx_sample_valid <= 1'b1;
    do @(negedge clk); while (tx_sample_ready !== 1'b1);
    @(posedge clk);
    tx_sample_valid <= 1'b0;
    @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tx_sample_ready !== 1'b1 && n < 40);
    chk({link_tx_sample, link_tx_ctrl}, 24'h12341E);
    // Ring while on-hook
    @(posedge clk);
    ring_on <= 1'b1;
    repeat (20) @(posedge clk);
    rdchk(8'h14, 8'h04);
    rdchk(8'h10, 8'h01);
    ring_on <= 1'b0;
    loop_code <= 5'h10;
    cid_on <= 1'b1;
    apb(1'b1, 8'h14, 32'h9);
    repeat (40) @(posedge clk);
    rdchk(8'h14, 8'h1B);
    rdchk(8'h30, 8'h50);
    rdchk(8'h10, 8'h00);
    // Drop, overload and loss of loop current, slow framing
    gap <= 4'h6;
    foreach (codes[i]) begin
      loop_code <= codes[i];
      dropout_on <= (codes[i] == 5'h00);
      repeat (40) @(posedge clk);
      rdchk(8'h30, {3'b010, codes[i]});
      chk(irq, |fexp[i]);
      rdchk(8'h10, fexp[i]);
    end
    // Reset in mid-run
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rdchk(8'h18, 8'h10);
    rdchk(8'h14, 8'h00);
    chk(link_enable, 1'b0);
    conclude();
  end
endmodule // tb_top
